// file: core/usd_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "usd_params.svh"

// Contract
// R1: After attach, run at full speed until the host drives a bus reset.
// R2: During bus reset send chirp; host handshake moves device to high speed.
// R3: In high speed, 3 ms without bus activity reverts to full speed.
// R4: After reversion, SE0 held 100 to 875 us restarts the chirp handshake.
// R5: No SE0 after reversion: stay full speed and treat bus as suspended.
// R6: The serial engine handles the protocol layer wholly in hardware.
// R7: D+ pull-up is routed only while pullup_connect is set.
// R8: Hardware reset clears pullup_connect, disconnecting the pull-up.
// R9: A USB bus reset leaves pullup_connect unchanged.
// R10: Firmware keeps pullup_connect low while bus power is absent.
// R11: After resume, register writes are blocked until the unlock code arrives.
// R12: The high-speed idle timer restarts on every bus activity.
module usd_link
    import usd_pkg::*;
#(
    parameter int IDLE_CYC = `USD_IDLE_CYC,
    parameter int RESET_MIN_CYC = `USD_RESET_MIN_CYC,
    parameter int CHIRP_CYC = `USD_CHIRP_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic line_se0,
    input wire logic line_j_idle,
    input wire logic bus_activity,
    input wire logic host_chirp_kj,
    input wire logic resume_seen,
    input wire logic pullup_connect_wr,
    input wire logic pullup_connect_val,
    input wire logic reg_wr_req,
    input wire logic unlock_wr,
    input wire logic [15:0] unlock_data,
    output logic pullup_resistor_pin,
    output logic hs_mode,
    output logic chirp_drive,
    output logic suspended,
    output logic reg_wr_en,
    output logic write_locked
);
    localparam int CW = 20;

    usd_state_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic pc_q, pc_d;
    logic lock_q, lock_d;
    logic wen_d;

    // Saturating increment used by the speed timer.
    function automatic logic [CW-1:0] inc_sat(input logic [CW-1:0] v);
        inc_sat = (v == {CW{1'b1}}) ? v : v + 20'h00001;
    endfunction

    // Speed state machine; the serial engine below this block does the packet work.
    always_comb begin
        st_d = st_q;
        cnt_d = inc_sat(cnt_q);
        unique case (st_q)
            USD_FS: begin
                // Full speed until SE0 lasts long enough to be a bus reset.
                if (!line_se0) begin
                    cnt_d = '0; // R1
                end else if (cnt_q >= CW'(RESET_MIN_CYC - 1)) begin
                    st_d = USD_CHIRP; // R1
                    cnt_d = '0;
                end
            end
            USD_CHIRP: begin
                if (host_chirp_kj) begin
                    st_d = USD_HS; // R2
                    cnt_d = '0;
                end else if (cnt_q >= CW'(CHIRP_CYC - 1)) begin
                    st_d = USD_FS; // R2
                    cnt_d = '0;
                end
            end
            USD_HS: begin
                // Packet decoding lives in the serial engine; only its activity flag is seen here.
                if (bus_activity) begin // R6
                    cnt_d = '0; // R12
                end else if (cnt_q >= CW'(IDLE_CYC - 1)) begin
                    st_d = USD_REVERT; // R3
                    cnt_d = '0;
                end
            end
            USD_REVERT: begin
                if (!line_se0) begin
                    st_d = USD_SUSPEND; // R5
                    cnt_d = '0;
                end else if (cnt_q >= CW'(RESET_MIN_CYC - 1)) begin
                    st_d = USD_CHIRP; // R4
                    cnt_d = '0;
                end
            end
            USD_SUSPEND: begin
                if (line_se0) begin
                    st_d = USD_FS;
                    cnt_d = '0;
                end else if (resume_seen || !line_j_idle) begin
                    st_d = USD_FS;
                    cnt_d = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= USD_FS;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Pull-up control and write lock; bus reset does not touch the pull-up bit.
    always_comb begin
        pc_d = pc_q; // R9
        if (pullup_connect_wr && !lock_q) begin
            pc_d = pullup_connect_val; // R7
        end
        lock_d = lock_q;
        if (unlock_wr && unlock_data == `USD_UNLOCK_CODE) begin
            lock_d = 1'b0; // R11
        end
        if (st_q == USD_SUSPEND && st_d == USD_FS && resume_seen) begin
            lock_d = 1'b1; // R11
        end
        wen_d = reg_wr_req && !lock_q; // R11
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= `USD_PULLUP_RST; // R8
            lock_q <= 1'b0;
            pullup_resistor_pin <= 1'b0;
            hs_mode <= 1'b0;
            chirp_drive <= 1'b0;
            suspended <= 1'b0;
            reg_wr_en <= 1'b0;
            write_locked <= 1'b0;
        end else begin
            pc_q <= pc_d;
            lock_q <= lock_d;
            pullup_resistor_pin <= pc_d; // R7
            hs_mode <= (st_d == USD_HS);
            chirp_drive <= (st_d == USD_CHIRP); // R2
            suspended <= (st_d == USD_SUSPEND); // R5
            reg_wr_en <= wen_d;
            write_locked <= lock_d;
        end
    end

    // Checks tying outputs to their causes.
    a_pullup_follows: assert property (@(posedge clk) disable iff (!rstn)
        pullup_resistor_pin == pc_q) else $error("pull-up pin differs from control bit"); // R7
    a_reset_pullup: assert property (@(posedge clk)
        !rstn |-> !pc_q) else $error("pull-up bit set during reset"); // R8
    a_hs_idle_revert: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_HS && cnt_q == CW'(IDLE_CYC - 1) && !bus_activity)
        |=> st_q == USD_REVERT) else $error("no reversion after idle timeout"); // R3
    a_activity_reload: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_HS && bus_activity) |=> cnt_q == '0 || st_q != USD_HS)
        else $error("idle timer not restarted by activity"); // R12
    a_se0_rechirp: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_REVERT && line_se0 && cnt_q == CW'(RESET_MIN_CYC - 1))
        |=> chirp_drive) else $error("no chirp after SE0 window"); // R4
    a_no_se0_suspend: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_REVERT && !line_se0) |=> suspended)
        else $error("idle bus not treated as suspend"); // R5
    a_chirp_to_hs: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_CHIRP && host_chirp_kj) |=> hs_mode && !chirp_drive)
        else $error("handshake did not select high speed"); // R2
    a_fs_until_reset: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_FS && !line_se0) |=> !hs_mode && !chirp_drive)
        else $error("left full speed without bus reset"); // R1
    a_locked_blocks: assert property (@(posedge clk) disable iff (!rstn)
        (lock_q && reg_wr_req) |=> !reg_wr_en) else $error("write passed while locked"); // R11
    a_bus_reset_keep: assert property (@(posedge clk) disable iff (!rstn)
        (line_se0 && !pullup_connect_wr) |=> $stable(pc_q))
        else $error("bus reset changed pull-up bit"); // R9

    // A short SE0 in full speed must not start the chirp early.
    a_fs_short_se0: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_FS && line_se0 && cnt_q < CW'(RESET_MIN_CYC - 1))
        |=> !chirp_drive && !hs_mode) else $error("chirp before reset window"); // R1

    // An unanswered chirp gives up and stays at full speed.
    a_chirp_timeout: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_CHIRP && !host_chirp_kj && cnt_q == CW'(CHIRP_CYC - 1))
        |=> !chirp_drive && !hs_mode) else $error("chirp did not fall back"); // R2

    // High speed is kept while the idle timer has not run out.
    a_hs_holds: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_HS && !bus_activity && cnt_q < CW'(IDLE_CYC - 1))
        |=> hs_mode) else $error("left high speed too early"); // R3

    // A quiet idle bus keeps the block in suspend.
    a_suspend_holds: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_SUSPEND && !line_se0 && line_j_idle && !resume_seen)
        |=> suspended) else $error("suspend left without cause"); // R5

    // Waking by resume must lock register writes.
    a_resume_locks: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == USD_SUSPEND && resume_seen) |=> write_locked)
        else $error("resume did not lock writes"); // R11

    // The right code releases the lock when no resume competes.
    a_unlock_clears: assert property (@(posedge clk) disable iff (!rstn)
        (unlock_wr && unlock_data == `USD_UNLOCK_CODE && !resume_seen)
        |=> !write_locked) else $error("unlock code ignored"); // R11

    // Pull-up writes are dropped while locked.
    a_locked_pullup: assert property (@(posedge clk) disable iff (!rstn)
        (lock_q && pullup_connect_wr) |=> $stable(pc_q))
        else $error("pull-up written while locked"); // R11

    // An unlocked write request passes on the next cycle.
    a_open_writes: assert property (@(posedge clk) disable iff (!rstn)
        (!lock_q && reg_wr_req) |=> reg_wr_en)
        else $error("write blocked while unlocked"); // R11
endmodule
`default_nettype wire

// file: inc/usd_params.svh
`ifndef USD_PARAMS_SVH
`define USD_PARAMS_SVH
`define USD_CLK_HZ 40000000
`define USD_IDLE_TIMEOUT_US 3000
`define USD_RESET_MIN_US 100
`define USD_RESET_MAX_US 875
`define USD_CHIRP_US 1000
`define USD_IDLE_CYC ((`USD_IDLE_TIMEOUT_US * 40) / 1)
`define USD_RESET_MIN_CYC (`USD_RESET_MIN_US * (`USD_CLK_HZ / 1000000))
`define USD_CHIRP_CYC (`USD_CHIRP_US * (`USD_CLK_HZ / 1000000))
`define USD_PULLUP_RST 1'b0
`define USD_UNLOCK_CODE 16'hAA37
`endif

// file: inc/usd_pkg.sv
package usd_pkg;
    typedef enum logic [2:0] {
        USD_FS,
        USD_CHIRP,
        USD_HS,
        USD_REVERT,
        USD_SUSPEND
    } usd_state_t;
endpackage

// file: test/usd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usd_host_model #(
    parameter int DLY = 4
) (
    input wire logic clk,
    input wire logic bus_rst,
    input wire logic hs_host,
    input wire logic chirp_drive,
    output logic line_se0,
    output logic line_j_idle,
    output logic host_chirp_kj
);
    int cnt = 0;
    // Host holds SE0 during a bus reset and, when hs_host is set, answers a chirp DLY + 1 cycles after chirp_drive rises.
    always @(posedge clk) begin
        line_se0 <= bus_rst;
        line_j_idle <= !bus_rst;
        cnt <= (chirp_drive && hs_host) ? cnt + 1 : 0;
        host_chirp_kj <= (cnt == DLY);
    end
    initial begin
        line_se0 = 1'b0;
        line_j_idle = 1'b1;
        host_chirp_kj = 1'b0;
    end
endmodule
`default_nettype wire

// file: test/usd_link_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "usd_params.svh"
module usd_link_tb_top;
    localparam int IDL = 50;
    localparam int RMN = 8;
    localparam int CHP = 20;
    logic clk = 0, rstn = 0, brst = 0, hsh = 0, act = 0, res = 0, pw = 0, pv = 0;
    logic rq = 0, uw = 0, se0, jid, kj, pin, hs, chp, sus, wen, lck, seen;
    logic [15:0] ud = 16'h0000;
    int mismatches = 0, samples_checked = 0;
    usd_host_model hm (.clk(clk), .bus_rst(brst), .hs_host(hsh), .chirp_drive(chp),
        .line_se0(se0), .line_j_idle(jid), .host_chirp_kj(kj));
    usd_link #(.IDLE_CYC(IDL), .RESET_MIN_CYC(RMN), .CHIRP_CYC(CHP)) dut (.clk(clk),
        .rstn(rstn), .line_se0(se0), .line_j_idle(jid), .bus_activity(act),
        .host_chirp_kj(kj), .resume_seen(res), .pullup_connect_wr(pw),
        .pullup_connect_val(pv), .reg_wr_req(rq), .unlock_wr(uw), .unlock_data(ud),
        .pullup_resistor_pin(pin), .hs_mode(hs), .chirp_drive(chp), .suspended(sus),
        .reg_wr_en(wen), .write_locked(lck));
    // Clock generator.
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t mismatch got %b want %b", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    task automatic wr_pu(input logic v);
        pv = v;
        pulse(pw);
    endtask
    task automatic reg_wr();
        rq = 1'b1;
        @(negedge clk);
        seen = wen;
        rq = 1'b0;
        @(negedge clk);
        seen = seen | wen;
    endtask
    task automatic bus_reset(input logic h);
        hsh = h;
        brst = 1'b1;
        for (int i = 0; i < RMN + 10 && chp !== 1'b1; i++) @(negedge clk);
        chk(chp, 1'b1);
        for (int i = 0; i < CHP + 10 && chp !== 1'b0; i++) @(negedge clk);
        chk(hs, h);
        brst = 1'b0;
        @(negedge clk);
        chk(pin, 1'b1);
    endtask
    task automatic t_idle();
        repeat (4) begin
            repeat (IDL - 10) @(negedge clk);
            pulse(act);
        end
        chk(hs, 1'b1);
        brst = 1'b1;
        for (int i = 0; i < IDL + 5 && hs !== 1'b0; i++) @(negedge clk);
        chk(hs, 1'b0);
        for (int i = 0; i < RMN + 10 && chp !== 1'b1; i++) @(negedge clk);
        chk(chp, 1'b1);
        for (int i = 0; i < CHP + 10 && chp !== 1'b0; i++) @(negedge clk);
        brst = 1'b0;
        chk(hs, 1'b1);
    endtask
    task automatic t_susp();
        for (int i = 0; i < IDL + 10 && sus !== 1'b1; i++) @(negedge clk);
        chk(sus, 1'b1);
        chk(hs, 1'b0);
        pulse(res);
        chk(lck, 1'b1);
        reg_wr();
        chk(seen, 1'b0);
        wr_pu(1'b0);
        chk(pin, 1'b1);
        ud = 16'h1234;
        pulse(uw);
        chk(lck, 1'b1);
        ud = `USD_UNLOCK_CODE;
        pulse(uw);
        chk(lck, 1'b0);
        reg_wr();
        chk(seen, 1'b1);
    endtask
    // Main sequence.
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk(pin, 1'b0);
        chk(hs, 1'b0);
        wr_pu(1'b1);
        chk(pin, 1'b1);
        bus_reset(1'b0);
        bus_reset(1'b1);
        t_idle();
        t_susp();
        wr_pu(1'b0);
        chk(pin, 1'b0);
        give_verdict();
    end
    // Watchdog against a hang.
    initial begin
        #500000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
